/* design/byte_buffer.sv */
// User data buffer of 2 Kbytes with first-in first-out order.
`timescale 1ns/100ps
module byte_buffer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic [11:0] count,
   output logic full,
   output logic empty
);
   logic [7:0] mem [mp_pkg::BUF_DEPTH];
   logic [mp_pkg::BUF_AW-1:0] wr_ptr_q;
   logic [mp_pkg::BUF_AW-1:0] rd_ptr_q;
   logic [11:0] count_q;
   logic do_wr;
   logic do_rd;

   assign full = (count_q == 12'h800);
   assign empty = (count_q == 12'h000);
   assign do_wr = wr_en && !full;
   assign do_rd = rd_en && !empty;
   assign rd_data = mem[rd_ptr_q];
   assign count = count_q;

   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[wr_ptr_q] <= wr_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= 12'h000;
      end
      else
      begin
         if (do_wr)
            wr_ptr_q <= wr_ptr_q + 11'h001;
         if (do_rd)
            rd_ptr_q <= rd_ptr_q + 11'h001;
         if (do_wr && !do_rd)
            count_q <= count_q + 12'h001;
         else if (do_rd && !do_wr)
            count_q <= count_q - 12'h001;
      end
   end
endmodule // byte_buffer

/* design/mp_pkg.sv */
// Shared constants for the multipoint timing pulse and slot control block.
package mp_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_LEVEL = 12'h008;
   localparam logic [11:0] ADDR_DIAG = 12'h00c;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_DELAY_LSB = 0;
   localparam int CTRL_DIAG_LSB = 8;
   localparam int CTRL_MODE_LSB = 16;
   localparam int CTRL_HS_BIT = 18;
   localparam int CTRL_MASTER_BIT = 19;
   localparam int STAT_CD_BIT = 0;
   localparam int STAT_DIAG_BIT = 1;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_TXE_BIT = 3;
   localparam int STAT_RXE_BIT = 4;
   localparam int STAT_OVF_BIT = 5;
   localparam int LEVEL_RX_LSB = 16;
   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [7:0] DELAY_RST = 8'hff;
   localparam logic [7:0] DELAY_OFF = 8'hff;
   localparam logic [7:0] DELAY_MAX = 8'hfe;
   localparam logic [7:0] DIAG_RST = 8'h00;
   localparam logic [7:0] DIAG_MAX = 8'h80;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 100000;
   localparam int PPS_STEP_PS = 542534;
   localparam int PPS_PULSE_MS = 2;
   localparam int PPS_PULSE_CYC = (PPS_PULSE_MS * 1000000000) / CLK_PERIOD_PS;
   localparam int PPS_LATE_US = 20;
   localparam int PPS_LATE_CYC = (PPS_LATE_US * 1000000) / CLK_PERIOD_PS;
   // ----------------------------------------------------------------
   // Buffers
   // ----------------------------------------------------------------
   localparam int BUF_AW = 11;
   localparam int BUF_DEPTH = 2048;
   localparam logic [11:0] CTS_LEVEL = 12'h7c0;
   localparam logic [11:0] BURST_LEVEL = 12'h040;
   localparam logic [7:0] BURST_IDLE_CYC = 8'h64;
   // ----------------------------------------------------------------
   // Modes and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TRIG_IMMEDIATE = 2'h0, TRIG_LINE = 2'h1, TRIG_BURST = 2'h2,
      TRIG_SPARE = 2'h3} trig_mode_t;
   typedef enum logic {BURST_FILL, BURST_SEND} burst_state_t;
endpackage

/* design/multipoint_ctrl.sv */
// Multipoint timing pulse relay, diagnostics slot interleave and slave transmit control.
//
// What this block does
// - Delay setting 255 disables the timing pulse; 0 to 254 enable it.
// - Master DTR pulse is reproduced each second on every slave's CD output.
// - Each delay step shifts the slave output pulse by 542.534 ns.
// - Higher delay setting shortens the slave delay; lower setting lengthens it.
// - Slave drives CD high for about 2 ms per pulse.
// - Calibrated slave pulse starts within 20 us of the master input pulse.
// - Diagnostics setting takes 0 to 128; zero disables diagnostics.
// - Nonzero setting N gives one of every N slots to diagnostics.
// - Pending user data goes before diagnostics data whenever the trigger mode lets it send.
// - Trigger mode 0 transmits user data as soon as it arrives, while handshake flow control is off or RTS is high.
// - Trigger mode 1 links to the master only while DTR is high.
// - Trigger mode 2 sends bursts and ignores handshake flow control.
// - In mode 1 an enabled handshake flow control overrides DTR sensing.
// - Separate 2 Kbyte transmit and receive user data buffers.
`timescale 1ns/100ps
module multipoint_ctrl #(
   parameter int PULSE_CYC = mp_pkg::PPS_PULSE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dtr_pin,
   input wire logic rts_pin,
   output logic cd_pin,
   output logic cts_pin,
   output logic link_req,
   output logic pps_tx_event,
   input wire logic pps_rx_event,
   input wire logic ser_in_valid,
   input wire logic [7:0] ser_in_data,
   output logic ser_in_ready,
   output logic ser_out_valid,
   output logic [7:0] ser_out_data,
   input wire logic ser_out_ready,
   input wire logic slot_start,
   output logic slot_tx_valid,
   output logic [7:0] slot_tx_data,
   output logic slot_tx_diag,
   input wire logic radio_rx_valid,
   input wire logic [7:0] radio_rx_data
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] delay_q;
   logic [7:0] diag_n_q;
   mp_pkg::trig_mode_t mode_q;
   logic hs_en_q;
   logic master_q;
   logic [7:0] diag_byte_q;
   logic diag_pend_q;
   logic ovf_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [1:0] pins_s;
   logic dtr_s;
   logic rts_s;
   logic dtr_prev_q;
   logic pps_en;
   logic pps_tx_q;
   logic wait_q;
   logic [31:0] acc_ps_q;
   logic [31:0] target_ps;
   logic [31:0] pulse_cnt_q;
   logic cd_q;
   logic [7:0] diag_cnt_q;
   logic diag_slot;
   logic tx_pop;
   logic rx_pop;
   logic [7:0] tx_rd;
   logic [7:0] rx_rd;
   logic [11:0] tx_cnt;
   logic [11:0] rx_cnt;
   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic hs_active;
   logic allow_user;
   mp_pkg::burst_state_t burst_q;
   logic [7:0] idle_q;
   logic ser_in_ready_q;
   logic cts_q;
   logic link_q;
   logic ser_out_valid_q;
   logic [7:0] ser_out_data_q;
   logic slot_valid_q;
   logic [7:0] slot_data_q;
   logic slot_diag_q;
   logic apb_wr;
   logic apb_setup;
   logic [7:0] wr_diag_n;

   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready_q && pwrite;

   // ----------------------------------------------------------------
   // Pin synchronisers and buffers
   // ----------------------------------------------------------------
   sync2 #(.W(2)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({rts_pin, dtr_pin}),
      .q(pins_s)
   );
   assign dtr_s = pins_s[0];
   assign rts_s = pins_s[1];

   byte_buffer u_txbuf (
      .clk(pclk),
      .rst_n(presetn),
      .wr_en(ser_in_valid && ser_in_ready_q),
      .wr_data(ser_in_data),
      .rd_en(tx_pop),
      .rd_data(tx_rd),
      .count(tx_cnt),
      .full(tx_full),
      .empty(tx_empty)
   );

   byte_buffer u_rxbuf (
      .clk(pclk),
      .rst_n(presetn),
      .wr_en(radio_rx_valid),
      .wr_data(radio_rx_data),
      .rd_en(rx_pop),
      .rd_data(rx_rd),
      .count(rx_cnt),
      .full(rx_full),
      .empty(rx_empty)
   );

   // ----------------------------------------------------------------
   // Register interface
   // ----------------------------------------------------------------
   assign wr_diag_n = (pwdata[15:8] > mp_pkg::DIAG_MAX) ? mp_pkg::DIAG_MAX : pwdata[15:8];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         delay_q <= mp_pkg::DELAY_RST;
         diag_n_q <= mp_pkg::DIAG_RST;
         mode_q <= mp_pkg::TRIG_IMMEDIATE;
         hs_en_q <= 1'b0;
         master_q <= 1'b0;
         diag_byte_q <= 8'h00;
      end
      else if (apb_wr && paddr == mp_pkg::ADDR_CTRL)
      begin
         delay_q <= pwdata[mp_pkg::CTRL_DELAY_LSB +: 8];
         diag_n_q <= wr_diag_n;
         mode_q <= mp_pkg::trig_mode_t'(pwdata[mp_pkg::CTRL_MODE_LSB +: 2]);
         hs_en_q <= pwdata[mp_pkg::CTRL_HS_BIT];
         master_q <= pwdata[mp_pkg::CTRL_MASTER_BIT];
      end
      else if (apb_wr && paddr == mp_pkg::ADDR_DIAG)
         diag_byte_q <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= 1'b1;
         if (apb_setup)
         begin
            pslverr_q <= 1'b0;
            case (paddr)
               mp_pkg::ADDR_CTRL:
                  prdata_q <= {12'h000, master_q, hs_en_q, mode_q, diag_n_q, delay_q};
               mp_pkg::ADDR_STATUS:
                  prdata_q <= {26'h0, ovf_q, rx_empty, tx_empty, link_q, diag_pend_q, cd_q};
               mp_pkg::ADDR_LEVEL:
                  prdata_q <= {4'h0, rx_cnt, 4'h0, tx_cnt};
               mp_pkg::ADDR_DIAG:
                  prdata_q <= {24'h0, diag_byte_q};
               default:
               begin
                  prdata_q <= 32'h0000_0000;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // Overflow flag: set by hardware, cleared by writing one; a set wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovf_q <= 1'b0;
      else if ((ser_in_valid && tx_full) || (radio_rx_valid && rx_full))
         ovf_q <= 1'b1;
      else if (apb_wr && paddr == mp_pkg::ADDR_STATUS && pwdata[mp_pkg::STAT_OVF_BIT])
         ovf_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Timing pulse: master capture
   // ----------------------------------------------------------------
   assign pps_en = (delay_q != mp_pkg::DELAY_OFF);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dtr_prev_q <= 1'b0;
         pps_tx_q <= 1'b0;
      end
      else
      begin
         dtr_prev_q <= dtr_s;
         pps_tx_q <= master_q && pps_en && dtr_s && !dtr_prev_q;
      end
   end

   // ----------------------------------------------------------------
   // Timing pulse: slave delay and CD pulse
   // ----------------------------------------------------------------
   // The wait is counted in picoseconds so that the fractional step stays linear.
   assign target_ps = 32'(mp_pkg::DELAY_MAX - delay_q) * 32'(mp_pkg::PPS_STEP_PS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_q <= 1'b0;
         acc_ps_q <= 32'h0000_0000;
      end
      else if (!pps_en || master_q)
      begin
         wait_q <= 1'b0;
         acc_ps_q <= 32'h0000_0000;
      end
      else if (pps_rx_event)
      begin
         wait_q <= 1'b1;
         acc_ps_q <= 32'h0000_0000;
      end
      else if (wait_q)
      begin
         if (acc_ps_q >= target_ps)
            wait_q <= 1'b0;
         acc_ps_q <= acc_ps_q + 32'(mp_pkg::CLK_PERIOD_PS);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cd_q <= 1'b0;
         pulse_cnt_q <= 32'h0000_0000;
      end
      else if (!pps_en || master_q)
      begin
         cd_q <= 1'b0;
         pulse_cnt_q <= 32'h0000_0000;
      end
      else if (wait_q && !pps_rx_event && acc_ps_q >= target_ps)
      begin
         cd_q <= 1'b1;
         pulse_cnt_q <= 32'(PULSE_CYC - 1);
      end
      else if (cd_q)
      begin
         if (pulse_cnt_q == 32'h0000_0000)
            cd_q <= 1'b0;
         else
            pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Transmit trigger modes
   // ----------------------------------------------------------------
   assign hs_active = hs_en_q && (mode_q != mp_pkg::TRIG_BURST);

   always_comb
   begin
      case (mode_q)
         mp_pkg::TRIG_LINE:
            allow_user = !tx_empty && (hs_en_q ? rts_s : dtr_s);
         mp_pkg::TRIG_BURST:
            allow_user = !tx_empty && (burst_q == mp_pkg::BURST_SEND);
         default:
            allow_user = !tx_empty && (!hs_active || rts_s);
      endcase
   end

   // Burst mode gathers data until a level is reached or the line goes idle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         burst_q <= mp_pkg::BURST_FILL;
         idle_q <= 8'h00;
      end
      else
      begin
         if (ser_in_valid || tx_empty)
            idle_q <= 8'h00;
         else if (idle_q != mp_pkg::BURST_IDLE_CYC)
            idle_q <= idle_q + 8'h01;
         case (burst_q)
            mp_pkg::BURST_FILL:
               if (tx_cnt >= mp_pkg::BURST_LEVEL || idle_q == mp_pkg::BURST_IDLE_CYC)
                  burst_q <= mp_pkg::BURST_SEND;
            mp_pkg::BURST_SEND:
               if (tx_empty)
                  burst_q <= mp_pkg::BURST_FILL;
            default:
               burst_q <= mp_pkg::BURST_FILL;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cts_q <= 1'b1;
         link_q <= 1'b0;
         ser_in_ready_q <= 1'b0;
      end
      else
      begin
         cts_q <= !hs_active || (tx_cnt < mp_pkg::CTS_LEVEL);
         link_q <= (mode_q == mp_pkg::TRIG_LINE) && !master_q && (hs_en_q ? rts_s : dtr_s);
         ser_in_ready_q <= (tx_cnt < 12'h7fe);
      end
   end

   // ----------------------------------------------------------------
   // Slot allocation
   // ----------------------------------------------------------------
   // A counter left above a newly lowered setting still yields the next diagnostics slot.
   assign diag_slot = (diag_n_q != 8'h00) && (diag_cnt_q >= diag_n_q - 8'h01);
   assign tx_pop = slot_start && allow_user;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         diag_cnt_q <= 8'h00;
      else if (diag_n_q == 8'h00 || diag_slot)
      begin
         if (slot_start || diag_n_q == 8'h00)
            diag_cnt_q <= 8'h00;
      end
      else if (slot_start)
         diag_cnt_q <= diag_cnt_q + 8'h01;
   end

   // Diagnostics pending: a software write wins over a send in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         diag_pend_q <= 1'b0;
      else if (apb_wr && paddr == mp_pkg::ADDR_DIAG)
         diag_pend_q <= 1'b1;
      else if (slot_start && !allow_user && diag_slot)
         diag_pend_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_valid_q <= 1'b0;
         slot_data_q <= 8'h00;
         slot_diag_q <= 1'b0;
      end
      else
      begin
         slot_valid_q <= 1'b0;
         slot_diag_q <= 1'b0;
         if (tx_pop)
         begin
            slot_valid_q <= 1'b1;
            slot_data_q <= tx_rd;
         end
         else if (slot_start && diag_slot && diag_pend_q)
         begin
            slot_valid_q <= 1'b1;
            slot_diag_q <= 1'b1;
            slot_data_q <= diag_byte_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial output from the receive buffer
   // ----------------------------------------------------------------
   assign rx_pop = !rx_empty && (!ser_out_valid_q || ser_out_ready);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ser_out_valid_q <= 1'b0;
         ser_out_data_q <= 8'h00;
      end
      else if (rx_pop)
      begin
         ser_out_valid_q <= 1'b1;
         ser_out_data_q <= rx_rd;
      end
      else if (ser_out_ready)
         ser_out_valid_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cd_pin = cd_q;
   assign cts_pin = cts_q;
   assign link_req = link_q;
   assign pps_tx_event = pps_tx_q;
   assign ser_in_ready = ser_in_ready_q;
   assign ser_out_valid = ser_out_valid_q;
   assign ser_out_data = ser_out_data_q;
   assign slot_tx_valid = slot_valid_q;
   assign slot_tx_data = slot_data_q;
   assign slot_tx_diag = slot_diag_q;
endmodule // multipoint_ctrl

/* design/sync2.sv */
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // sync2

/* verification/mp_monitor.sv */
// Concurrent checks on the multipoint timing pulse and slot control ports.
`timescale 1ns/100ps
module mp_monitor #(
   parameter int PULSE_CYC = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic dtr_pin,
   input wire logic cd_pin,
   input wire logic cts_pin,
   input wire logic pps_tx_event,
   input wire logic pps_rx_event,
   input wire logic slot_start,
   input wire logic slot_tx_valid,
   input wire logic slot_tx_diag
);
   // -----------------------------------------------
   // Shadow of the control word and pulse length
   // -----------------------------------------------
   logic [19:0] ctl_q;
   int hcnt_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctl_q <= 20'h000ff;
      else if (psel && penable && pwrite && pready && paddr == mp_pkg::ADDR_CTRL)
         ctl_q <= pwdata[19:0];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hcnt_q <= 0;
      else
         hcnt_q <= cd_pin ? hcnt_q + 1 : 0;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_pps_off: assert property (ctl_q[7:0] == 8'hff |=> !cd_pin)
      else $error("cd high while relay off");
   chk_cd_start: assert property (pps_rx_event && !ctl_q[19] && ctl_q[7:0] == 8'hfe |-> ##2 cd_pin)
      else $error("cd pulse late");
   chk_cd_width: assert property (cd_pin |-> hcnt_q < PULSE_CYC)
      else $error("cd pulse too long");
   chk_pps_tx: assert property ($rose(dtr_pin) && ctl_q[19] && ctl_q[7:0] != 8'hff |-> ##[2:4] pps_tx_event)
      else $error("no pulse sent on dtr rise");
   chk_tx_once: assert property (pps_tx_event |=> !pps_tx_event)
      else $error("pulse event too long");
   chk_slot_cause: assert property (slot_tx_valid |-> $past(slot_start))
      else $error("slot byte without slot");
   chk_diag_off: assert property (slot_tx_diag |-> ctl_q[15:8] != 8'h00 && $past(slot_start))
      else $error("diag byte while disabled");
   chk_burst_cts: assert property (ctl_q[17:16] == 2'h2 |=> cts_pin)
      else $error("cts low in burst mode");
endmodule // mp_monitor

/* verification/serial_equip.sv */
// Model of the serial equipment attached to the transceiver.
`timescale 1ns/100ps
module serial_equip (
   input wire logic pclk,
   input wire logic presetn,
   output logic dtr_pin,
   output logic ser_in_valid,
   output logic [7:0] ser_in_data,
   input wire logic ser_in_ready,
   input wire logic ser_out_valid,
   input wire logic [7:0] ser_out_data,
   output logic ser_out_ready
);
   int seed = 32'h7181;
   logic [7:0] got[$];
   initial
   begin
      dtr_pin = 0;
      ser_in_valid = 0;
      ser_in_data = 0;
   end
   task set_dtr(input logic v);
      dtr_pin <= v;
   endtask
   task send(input logic [7:0] v);
      ser_in_valid <= 1;
      ser_in_data <= v;
      do
         @(posedge pclk);
      while (ser_in_ready !== 1'b1);
      ser_in_valid <= 0;
      ser_in_data <= ~v;
   endtask
   always @(posedge pclk)
   begin
      ser_out_ready <= presetn && ($random(seed) % 3 != 0);
      if (ser_out_valid === 1'b1 && ser_out_ready === 1'b1)
         got.push_back(ser_out_data);
   end
endmodule // serial_equip

/* verification/tb.sv */
// Self-checking testbench for the multipoint timing pulse and slot control block.
`timescale 1ns/100ps
module tb;
   localparam int PULSE_CYC = 50;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, rts_pin = 0, cd_pin, cts_pin, link_req, pps_tx_event, pps_rx_event = 0;
   logic dtr_pin, ser_in_valid, ser_in_ready, ser_out_valid, ser_out_ready, slot_start = 0;
   logic slot_tx_valid, slot_tx_diag, radio_rx_valid = 0;
   logic [7:0] ser_in_data, ser_out_data, slot_tx_data, radio_rx_data = 0, b;
   logic [7:0] dl[3] = '{8'hfe, 8'hfa, 8'hc8};
   logic [7:0] txq[$], rxq[$];
   int n_fail = 0, tests_run = 0, seed = 32'h7181, n, k;
   always #50 pclk = ~pclk;
   multipoint_ctrl #(.PULSE_CYC(PULSE_CYC)) DUT (.*);
   serial_equip eq (.*);
   // -----------------------------------------------
   // Bus, slot and compare tasks
   // -----------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         n_fail++;
         $display("FAIL %s exp %h got %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task strobe();
      slot_start <= 1;
      @(posedge pclk);
      slot_start <= 0;
      @(posedge pclk);
   endtask
   task slot(input logic v, input logic g, input logic [7:0] d);
      strobe();
      chk("slot_valid", v, slot_tx_valid);
      chk("slot_diag", g, slot_tx_diag);
      if (v)
         chk("slot_data", d, slot_tx_data);
   endtask
   task put();
      b = 8'($random(seed));
      txq.push_back(b);
      eq.send(b);
      repeat (4) @(posedge pclk);
   endtask
   task complete_run();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #2000000;
      n_fail++;
      complete_run();
   end
   // -----------------------------------------------
   // Main sequence
   // -----------------------------------------------
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      apb(0, mp_pkg::ADDR_CTRL, 0);
      chk("ctrl_rst", 32'h000000ff, rd);
      apb(0, mp_pkg::ADDR_STATUS, 0);
      chk("status_rst", 32'h00000018, rd);
      apb(0, 12'h010, 0);
      chk("unmapped_err", 1, er);
      apb(1, mp_pkg::ADDR_CTRL, 32'h0000c8ff);
      apb(0, mp_pkg::ADDR_CTRL, 0);
      chk("diag_clamp", 32'h000080ff, rd);
      chk("mapped_err", 0, er);
      apb(1, mp_pkg::ADDR_CTRL, 32'h00080000);
      eq.set_dtr(1);
      k = 0;
      repeat (8)
      begin
         @(posedge pclk);
         k += (pps_tx_event === 1'b1);
      end
      eq.set_dtr(0);
      chk("pps_tx", 1, k);
      foreach (dl[i])
      begin
         apb(1, mp_pkg::ADDR_CTRL, {24'h0, dl[i]});
         pps_rx_event <= 1;
         @(posedge pclk);
         pps_rx_event <= 0;
         for (n = 0; cd_pin !== 1'b1 && n < 400; n++)
            @(posedge pclk);
         chk("cd_delay", ((254 - dl[i]) * 542534 + 99999) / 100000 + 2, n);
         for (k = 0; cd_pin === 1'b1 && k < 400; k++)
            @(posedge pclk);
         chk("cd_width", PULSE_CYC, k);
      end
      apb(1, mp_pkg::ADDR_CTRL, 32'h000000ff);
      pps_rx_event <= 1;
      @(posedge pclk);
      pps_rx_event <= 0;
      k = 0;
      repeat (60)
      begin
         @(posedge pclk);
         k += (cd_pin === 1'b1);
      end
      chk("cd_off", 0, k);
      put();
      put();
      slot(1, 0, txq.pop_front());
      slot(1, 0, txq.pop_front());
      slot(0, 0, 0);
      apb(1, mp_pkg::ADDR_DIAG, 32'h5a);
      apb(1, mp_pkg::ADDR_CTRL, 32'h000003ff);
      for (n = 0; n < 3 && slot_tx_diag !== 1'b1; n++)
         strobe();
      chk("diag_seen", 1, slot_tx_diag);
      chk("diag_data", 32'h5a, slot_tx_data);
      apb(1, mp_pkg::ADDR_DIAG, 32'h3c);
      put();
      slot(1, 0, txq.pop_front());
      slot(0, 0, 0);
      slot(1, 1, 8'h3c);
      apb(1, mp_pkg::ADDR_DIAG, 32'h77);
      slot(0, 0, 0);
      slot(0, 0, 0);
      put();
      slot(1, 0, txq.pop_front());
      apb(1, mp_pkg::ADDR_CTRL, 32'h000000ff);
      repeat (3) slot(0, 0, 0);
      apb(1, mp_pkg::ADDR_CTRL, 32'h000300ff);
      put();
      slot(1, 0, txq.pop_front());
      apb(1, mp_pkg::ADDR_CTRL, 32'h000100ff);
      put();
      slot(0, 0, 0);
      eq.set_dtr(1);
      repeat (4) @(posedge pclk);
      chk("link_req", 1, link_req);
      slot(1, 0, txq.pop_front());
      rts_pin <= 1;
      apb(1, mp_pkg::ADDR_CTRL, 32'h000500ff);
      eq.set_dtr(0);
      put();
      slot(1, 0, txq.pop_front());
      rts_pin <= 0;
      eq.set_dtr(1);
      put();
      slot(0, 0, 0);
      apb(0, mp_pkg::ADDR_LEVEL, 0);
      chk("level", 32'h00000001, rd);
      chk("ser_in_ready", 1, ser_in_ready);
      apb(1, mp_pkg::ADDR_CTRL, 32'h000600ff);
      chk("cts_burst", 1, cts_pin);
      repeat (110) @(posedge pclk);
      slot(1, 0, txq.pop_front());
      repeat (3)
      begin
         b = 8'($random(seed));
         rxq.push_back(b);
         radio_rx_valid <= 1;
         radio_rx_data <= b;
         @(posedge pclk);
      end
      radio_rx_valid <= 0;
      radio_rx_data <= ~b;
      repeat (40) @(posedge pclk);
      chk("rx_count", 3, eq.got.size());
      foreach (rxq[i])
         chk("rx_data", rxq[i], eq.got[i]);
      complete_run();
   end
endmodule // tb
bind multipoint_ctrl mp_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.*);
